//--- verilog/crc_check_pkg.sv
// Shared constants, state codes and carrier types of the configuration memory checker.
`default_nettype none
package crc_check_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          OSC_MHZ       = 80;
  localparam int          DIV_EXP_MAX   = 8;
  localparam int          DIV_CNT_W     = 8;

  // ************************************************************
  // Check codes
  // ************************************************************
  localparam logic [31:0] CRC32_POLY     = 32'hEDB88320;
  localparam logic [31:0] CRC32_INIT     = 32'hFFFFFFFF;
  localparam logic [15:0] CRC16_POLY     = 16'h8408;
  localparam logic [15:0] CRC16_INIT     = 16'hFFFF;
  localparam logic [31:0] EXPECTED_RESET = 32'h00000000;
  localparam logic [31:0] SIGNATURE_OK   = 32'h00000000;

  // ************************************************************
  // Test port
  // ************************************************************
  localparam int          IR_LEN                    = 10;
  localparam logic [9:0]  EXPECTED_VALUE_SCAN_INSTR = 10'h015;
  localparam logic [9:0]  IR_CAPTURE                = 10'h001;
  localparam logic [9:0]  IR_RESET                  = 10'h3FF;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [3:0] {
    TAP_RESET    = 4'h0,
    TAP_IDLE     = 4'h1,
    TAP_SEL_DR   = 4'h3,
    TAP_CAP_DR   = 4'h2,
    TAP_SHIFT_DR = 4'h6,
    TAP_EX1_DR   = 4'h7,
    TAP_PAUSE_DR = 4'h5,
    TAP_EX2_DR   = 4'h4,
    TAP_UPD_DR   = 4'hC,
    TAP_SEL_IR   = 4'hD,
    TAP_CAP_IR   = 4'hF,
    TAP_SHIFT_IR = 4'hE,
    TAP_EX1_IR   = 4'hA,
    TAP_PAUSE_IR = 4'hB,
    TAP_EX2_IR   = 4'h9,
    TAP_UPD_IR   = 4'h8
  } tap_state_t;

  typedef enum logic [1:0] {
    MODE_CONFIG = 2'h0,
    MODE_USER   = 2'h1
  } chk_mode_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } cfg_word_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jtag_pins_t;

endpackage
`default_nettype wire

//--- verilog/frame_crc_checker.sv
// Per-frame 16-bit check of the configuration stream.
`default_nettype none
module frame_crc_checker
  import crc_check_pkg::*;
#(
  parameter int FRAME_WORDS = 16
) (
  // Clock and reset
  input  wire logic      clk_in,
  input  wire logic      reset_in,
  // Stream words
  input  wire cfg_word_t word_in,
  // Status
  output logic           frame_error_out
);

  localparam int CNT_W = $clog2(FRAME_WORDS + 1);
  localparam logic [CNT_W-1:0] LAST_DATA = CNT_W'(FRAME_WORDS - 1);

  logic [CNT_W-1:0] count_r;
  logic [15:0]      crc_r;
  logic             error_r;

  function automatic logic [15:0] crc16_word(input logic [15:0] c, input logic [15:0] d);
    logic [15:0] x;
    x = c;
    for (int i = 0; i < 16; i++) begin
      x = (x[0] ^ d[i]) ? ((x >> 1) ^ CRC16_POLY) : (x >> 1);
    end
    return x;
  endfunction

  // The word after the last data word is the check value itself.
  wire         at_check  = (count_r == CNT_W'(FRAME_WORDS));
  wire  [15:0] crc_nxt   = crc16_word(crc_r, word_in.data);
  wire         mismatch  = word_in.valid && at_check && (word_in.data != crc_r);

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      count_r <= '0;
      crc_r   <= CRC16_INIT;
      error_r <= 1'b0;
    end else if (word_in.valid) begin
      count_r <= at_check ? '0 : count_r + 1'b1;
      crc_r   <= at_check ? CRC16_INIT : crc_nxt;
      if (mismatch) begin
        error_r <= 1'b1;
      end
    end
  end

  assign frame_error_out = error_r;

  // ************************************************************
  // Checks
  // ************************************************************
  a_frame_mismatch_flag: assert property (@(posedge clk_in) disable iff (reset_in)
    mismatch |=> frame_error_out) else $error("frame mismatch not flagged");

  a_frame_status_sticky: assert property (@(posedge clk_in) disable iff (reset_in)
    frame_error_out |=> frame_error_out) else $error("frame status cleared early");

  a_frame_count_wrap: assert property (@(posedge clk_in) disable iff (reset_in)
    (word_in.valid && count_r == LAST_DATA) |=> at_check) else $error("frame length wrong");

endmodule
`default_nettype wire

//--- verilog/config_memory_crc_checker.sv
// Configuration memory checker: frame check, continuous 32-bit check, test port access.
// ************************************************************
// Operation
// - Error pin high when corruption found.
// - Error pin open-drain, only when enabled.
// - One 32-bit check value covers memory.
// - Frame check value shifted in after frame.
// - Frame mismatch drives status low.
// - Frame length is a device parameter.
// - Signature and storage registers, 32 bits.
// - Non-zero signature means error.
// - Storage loaded at end of configuration.
// - Storage value feeds compute-and-compare circuit.
// - Scan instruction makes storage a shift chain in user mode.
// - Checking continues during scan instruction.
// - Wrong expected value yields reported error.
// - Instruction code selects storage between TDI, TDO in user mode.
// - Flag held one pass, no history.
// - Check clock is oscillator over 2^n.
// - Check uses IEEE 802 32-bit polynomial.
// ************************************************************
`default_nettype none
module config_memory_crc_checker
  import crc_check_pkg::*;
#(
  parameter int CRAM_WORDS   = 64,
  parameter int FRAME_WORDS  = 16,
  parameter int DIV_EXP      = 0,
  parameter bit ERROR_PIN_EN = 1'b1
) (
  // Clock and reset
  input  wire logic                          clk_in,
  input  wire logic                          reset_in,
  // Configuration stream
  input  wire cfg_word_t                     cfg_word_in,
  input  wire logic                          cfg_done_in,
  input  wire logic [31:0]                   cfg_expected_in,
  output logic                               status_n_out,
  // Configuration memory read port
  output logic [$clog2(CRAM_WORDS)-1:0]      cram_addr_out,
  input  wire logic [31:0]                   cram_data_in,
  // Error pin, open drain
  input  wire logic                          error_pin_in,
  output logic                               error_pin_out,
  output logic                               error_pin_oe_out,
  // Test port pins
  input  wire jtag_pins_t                    jtag_in,
  output logic                               tdo_out,
  output logic                               tdo_oe_out,
  // Observation
  output logic [31:0]                        signature_out,
  output logic                               user_mode_out
);

  localparam int AW = $clog2(CRAM_WORDS);
  localparam logic [AW-1:0]        LAST_ADDR = AW'(CRAM_WORDS - 1);
  localparam logic [DIV_CNT_W-1:0] DIV_LAST  = DIV_CNT_W'((1 << DIV_EXP) - 1);

  // ************************************************************
  // Mode and divided check tick
  // ************************************************************
  chk_mode_t              mode_r;
  logic [DIV_CNT_W-1:0]   div_cnt_r;
  logic [AW-1:0]          addr_r;
  logic [31:0]            crc_r;
  logic [31:0]            signature_r;
  logic [31:0]            expected_r;
  logic                   error_r;
  logic                   frame_error;

  // The checker steps once per 2^n cycles, standing in for the divided oscillator.
  wire user     = (mode_r == MODE_USER);
  wire tick     = user && (div_cnt_r == DIV_LAST);
  wire pass_end = tick && (addr_r == LAST_ADDR);

  function automatic logic [31:0] crc32_word(input logic [31:0] c, input logic [31:0] d);
    logic [31:0] x;
    x = c;
    for (int i = 0; i < 32; i++) begin
      x = (x[0] ^ d[i]) ? ((x >> 1) ^ CRC32_POLY) : (x >> 1);
    end
    return x;
  endfunction

  wire [31:0] crc_nxt       = crc32_word(crc_r, cram_data_in);
  wire [31:0] signature_nxt = crc_nxt ^ expected_r;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mode_r    <= MODE_CONFIG;
      div_cnt_r <= '0;
    end else begin
      if (cfg_done_in && !frame_error) begin
        mode_r <= MODE_USER;
      end
      div_cnt_r <= tick || !user ? '0 : div_cnt_r + 1'b1;
    end
  end

  // ************************************************************
  // Continuous pass over configuration memory
  // ************************************************************
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      addr_r      <= '0;
      crc_r       <= CRC32_INIT;
      signature_r <= SIGNATURE_OK;
      error_r     <= 1'b0;
    end else if (pass_end) begin
      addr_r      <= '0;
      crc_r       <= CRC32_INIT;
      signature_r <= signature_nxt;
      error_r     <= (signature_nxt != SIGNATURE_OK);
    end else if (tick) begin
      addr_r <= addr_r + 1'b1;
      crc_r  <= crc_nxt;
    end
  end

  // ************************************************************
  // Frame check during configuration
  // ************************************************************
  cfg_word_t cfg_word_gated;
  assign cfg_word_gated = '{valid: cfg_word_in.valid && !user, data: cfg_word_in.data};

  frame_crc_checker #(
    .FRAME_WORDS (FRAME_WORDS)
  ) u_frame (
    .clk_in          (clk_in),
    .reset_in        (reset_in),
    .word_in         (cfg_word_gated),
    .frame_error_out (frame_error)
  );

  // ************************************************************
  // Test port: synchronisers and controller
  // ************************************************************
  jtag_pins_t  sync1_r;
  jtag_pins_t  sync2_r;
  logic        tck_d_r;
  tap_state_t  tap_r;
  logic [9:0]  ir_sh_r;
  logic [9:0]  ir_r;
  logic        bypass_r;
  logic        tdo_r;
  logic        tdo_oe_r;

  // The synchronisers run through reset, so a test clock parked high is not
  // seen as a fresh rising edge once reset is released.
  always_ff @(posedge clk_in) begin
    sync1_r <= jtag_in;
    sync2_r <= sync1_r;
    tck_d_r <= sync2_r.tck;
  end

  wire tck_rise  = sync2_r.tck && !tck_d_r;
  wire tck_fall  = !sync2_r.tck && tck_d_r;
  wire scan_hit  = user && (ir_r == EXPECTED_VALUE_SCAN_INSTR);
  wire dr_shift  = tck_rise && (tap_r == TAP_SHIFT_DR);
  wire scan_step = dr_shift && scan_hit;

  function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
    unique case (s)
      TAP_RESET:    return m ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:     return m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR:   return m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR:   return m ? TAP_EX1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: return m ? TAP_EX1_DR : TAP_SHIFT_DR;
      TAP_EX1_DR:   return m ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: return m ? TAP_EX2_DR : TAP_PAUSE_DR;
      TAP_EX2_DR:   return m ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR:   return m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR:   return m ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR:   return m ? TAP_EX1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: return m ? TAP_EX1_IR : TAP_SHIFT_IR;
      TAP_EX1_IR:   return m ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: return m ? TAP_EX2_IR : TAP_PAUSE_IR;
      TAP_EX2_IR:   return m ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR:   return m ? TAP_SEL_DR : TAP_IDLE;
    endcase
  endfunction

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tap_r    <= TAP_RESET;
      ir_sh_r  <= IR_RESET;
      ir_r     <= IR_RESET;
      bypass_r <= 1'b0;
    end else if (tck_rise) begin
      tap_r <= tap_next(tap_r, sync2_r.tms);
      unique case (tap_r)
        TAP_RESET:    ir_r     <= IR_RESET;
        TAP_CAP_IR:   ir_sh_r  <= IR_CAPTURE;
        TAP_SHIFT_IR: ir_sh_r  <= {sync2_r.tdi, ir_sh_r[9:1]};
        TAP_UPD_IR:   ir_r     <= ir_sh_r;
        TAP_CAP_DR:   bypass_r <= 1'b0;
        TAP_SHIFT_DR: bypass_r <= sync2_r.tdi;
        default:      bypass_r <= bypass_r;
      endcase
    end
  end

  // TDO changes on the falling test clock so the host samples a settled bit.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tdo_r    <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe_r <= (tap_r == TAP_SHIFT_DR) || (tap_r == TAP_SHIFT_IR);
      tdo_r    <= (tap_r == TAP_SHIFT_IR) ? ir_sh_r[0] :
                  scan_hit ? expected_r[0] : bypass_r;
    end
  end

  // ************************************************************
  // Storage register
  // ************************************************************
  // The checker keeps reading this value while it is scanned; a pass that
  // overlaps a scan sees a mix of old and new bits and may flag once.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      expected_r <= EXPECTED_RESET;
    end else if (cfg_done_in && !user) begin
      expected_r <= cfg_expected_in;
    end else if (scan_step) begin
      expected_r <= {sync2_r.tdi, expected_r[31:1]};
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign error_pin_out    = 1'b0;
  assign error_pin_oe_out = ERROR_PIN_EN && !error_r;
  assign status_n_out     = !frame_error;
  assign cram_addr_out    = addr_r;
  assign signature_out    = signature_r;
  assign user_mode_out    = user;
  assign tdo_out          = tdo_r;
  assign tdo_oe_out       = tdo_oe_r;

  // ************************************************************
  // Checks
  // ************************************************************
  a_flag_from_sig: assert property (@(posedge clk_in) disable iff (reset_in)
    pass_end |=> (error_r == (signature_r != SIGNATURE_OK))) else $error("flag disagrees");

  a_sig_zero_match: assert property (@(posedge clk_in) disable iff (reset_in)
    (pass_end && crc_nxt == expected_r) |=> (signature_r == SIGNATURE_OK))
    else $error("matching pass gave nonzero signature");

  a_flag_holds_pass: assert property (@(posedge clk_in) disable iff (reset_in)
    !pass_end |=> $stable(error_r)) else $error("flag changed inside a pass");

  a_pin_released_err: assert property (@(posedge clk_in) disable iff (reset_in)
    error_r |-> (!error_pin_oe_out && !error_pin_out)) else $error("pin pulled low on error");

  a_pin_drive_enable: assert property (@(posedge clk_in) disable iff (reset_in)
    (!ERROR_PIN_EN || error_r) |-> !error_pin_oe_out) else $error("pin driven while disabled");

  a_store_cfg_load: assert property (@(posedge clk_in) disable iff (reset_in)
    (cfg_done_in && !user) |=> (expected_r == $past(cfg_expected_in)))
    else $error("storage not loaded at end of configuration");

  a_scan_shift_in: assert property (@(posedge clk_in) disable iff (reset_in)
    scan_step |=> (expected_r[31] == $past(sync2_r.tdi))) else $error("scan bit lost");

  a_pass_restart: assert property (@(posedge clk_in) disable iff (reset_in)
    pass_end |=> (addr_r == '0 && crc_r == CRC32_INIT)) else $error("pass did not restart");

  a_scan_keeps_run: assert property (@(posedge clk_in) disable iff (reset_in)
    (scan_step && tick && !pass_end) |=> (addr_r == $past(addr_r) + 1'b1))
    else $error("checking stalled during scan");

  a_tick_spacing: assert property (@(posedge clk_in) disable iff (reset_in)
    tick |=> !tick[*1] or (DIV_EXP == 0)) else $error("tick spacing wrong");

endmodule
`default_nettype wire

//--- verif/crc_partner.sv
// Far-side model: configuration memory, error pin with pull-up, test port host.
`default_nettype none
module crc_partner
  import crc_check_pkg::*;
#(
  parameter int CRAM_WORDS = 8
) (
  // Clock
  input  wire logic                          clk_in,
  // Memory read port
  input  wire logic [$clog2(CRAM_WORDS)-1:0] cram_addr_in,
  output logic      [31:0]                   cram_data_out,
  // Error pin
  input  wire logic                          error_pin_drv_in,
  input  wire logic                          error_pin_oe_in,
  output logic                               error_pin_out,
  // Test port
  output var jtag_pins_t                     jtag_out,
  input  wire logic                          tdo_in,
  input  wire logic                          tdo_oe_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [CRAM_WORDS];
  assign cram_data_out = mem[cram_addr_in];
  // A released pin is lifted high by the resistor, so a dead driver reads as an error.
  assign error_pin_out = error_pin_oe_in ? error_pin_drv_in : 1'b1;
  initial jtag_out = '0;
  // ************************************************************
  // Test port host
  // ************************************************************
  // Levels last five clocks because the device sees the pins through two flops.
  task automatic tck_pulse(input logic tms, input logic tdi, output logic tdo);
    jtag_out.tck = 1'b0;
    jtag_out.tms = tms;
    jtag_out.tdi = tdi;
    repeat (5) @(posedge clk_in);
    #1;
    // A released data output reads as the host's pull-up level.
    tdo = tdo_oe_in ? tdo_in : 1'b1;
    jtag_out.tck = 1'b1;
    repeat (5) @(posedge clk_in);
    #1;
  endtask
  task automatic walk(input logic [9:0] seq, input int n);
    logic b;
    for (int i = 0; i < n; i++) tck_pulse(seq[i], 1'b0, b);
  endtask
  // Replaces the expected value and returns what was shifted out.
  task automatic scan_expected(input logic [31:0] new_val, output logic [31:0] old_val);
    logic b;
    walk(10'b0011011111, 10);
    for (int i = 0; i < IR_LEN; i++) begin
      tck_pulse(i == IR_LEN - 1, EXPECTED_VALUE_SCAN_INSTR[i], b);
    end
    walk(10'b0000000101, 5);
    for (int i = 0; i < 32; i++) begin
      tck_pulse(i == 31, new_val[i], old_val[i]);
    end
    walk(10'b0000000001, 2);
  endtask
endmodule
`default_nettype wire

//--- verif/config_memory_crc_checker_test.sv
// Self-checking bench of the configuration memory checker.
`default_nettype none
module config_memory_crc_checker_test;
  timeunit 1ns;
  timeprecision 1ps;
  import crc_check_pkg::*;
  localparam int CW = 8;
  localparam int FW = 4;
  localparam int AW = $clog2(CW);
  logic        clk_in = 1'b0;
  logic        reset_in = 1'b1;
  cfg_word_t   cfg_word_in = '0;
  logic        cfg_done_in = 1'b0;
  logic [31:0] cfg_expected_in = '0;
  logic        status_n_out;
  logic [AW-1:0] cram_addr;
  logic [31:0] cram_data;
  logic        error_pin;
  logic        error_pin_oe;
  logic        error_drv;
  jtag_pins_t  jtag;
  logic        tdo;
  logic        tdo_oe;
  logic [31:0] signature_out;
  logic        user_mode_out;
  logic [31:0] good;
  logic [31:0] wrong;
  logic [31:0] old;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          k;
  int          b;
  always #(CLK_PERIOD_NS / 2) clk_in = ~clk_in;
  config_memory_crc_checker #(.CRAM_WORDS(CW), .FRAME_WORDS(FW), .DIV_EXP(0),
    .ERROR_PIN_EN(1'b1)) i_config_memory_crc_checker (
    .clk_in(clk_in), .reset_in(reset_in), .cfg_word_in(cfg_word_in),
    .cfg_done_in(cfg_done_in), .cfg_expected_in(cfg_expected_in),
    .status_n_out(status_n_out), .cram_addr_out(cram_addr), .cram_data_in(cram_data),
    .error_pin_in(error_pin), .error_pin_out(error_drv), .error_pin_oe_out(error_pin_oe),
    .jtag_in(jtag), .tdo_out(tdo), .tdo_oe_out(tdo_oe), .signature_out(signature_out),
    .user_mode_out(user_mode_out));
  crc_partner #(.CRAM_WORDS(CW)) i_crc_partner (
    .clk_in(clk_in), .cram_addr_in(cram_addr), .cram_data_out(cram_data),
    .error_pin_drv_in(error_drv), .error_pin_oe_in(error_pin_oe),
    .error_pin_out(error_pin), .jtag_out(jtag), .tdo_in(tdo), .tdo_oe_in(tdo_oe));
  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // A hung handshake would otherwise stall the run forever.
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  function automatic logic [31:0] crc32_of_mem();
    logic [31:0] c;
    c = CRC32_INIT;
    for (int w = 0; w < CW; w++) begin
      for (int i = 0; i < 32; i++) begin
        c = (c >> 1) ^ ((c[0] ^ i_crc_partner.mem[w][i]) ? CRC32_POLY : 32'h00000000);
      end
    end
    return c;
  endfunction
  task automatic send_frame(input logic [15:0] flip);
    logic [15:0] q[$];
    logic [15:0] c;
    c = CRC16_INIT;
    for (int w = 0; w < FW; w++) begin
      q.push_back(16'($urandom));
      for (int i = 0; i < 16; i++) begin
        c = (c >> 1) ^ ((c[0] ^ q[w][i]) ? CRC16_POLY : 16'h0000);
      end
    end
    q.push_back(c ^ flip);
    foreach (q[i]) begin
      cfg_word_in = '{valid: 1'b1, data: q[i]};
      tick(1);
    end
    cfg_word_in.valid = 1'b0;
    tick(1);
    check(status_n_out, (flip == 16'h0000), "frame status");
  endtask
  task automatic enter_user(input logic [31:0] val, input logic exp_user);
    cfg_expected_in = val;
    cfg_done_in = 1'b1;
    tick(1);
    cfg_done_in = 1'b0;
    tick(1);
    check(user_mode_out, exp_user, "user mode");
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    void'($urandom(27915));
    for (int i = 0; i < CW; i++) i_crc_partner.mem[i] = $urandom;
    tick(6);
    reset_in = 1'b0;
    check(status_n_out, 1'b1, "status after reset");
    check(error_pin, 1'b0, "pin after reset");
    send_frame(16'h0000);
    send_frame(16'h0000);
    good = crc32_of_mem();
    enter_user(good, 1'b1);
    tick(2 * CW + 4);
    check(signature_out, SIGNATURE_OK, "clean signature");
    check(error_pin, 1'b0, "clean pin");
    k = $urandom_range(CW - 1);
    b = $urandom_range(31);
    i_crc_partner.mem[k][b] = ~i_crc_partner.mem[k][b];
    tick(2 * CW + 4);
    check(signature_out, crc32_of_mem() ^ good, "upset signature");
    check(error_pin, 1'b1, "upset pin");
    i_crc_partner.mem[k][b] = ~i_crc_partner.mem[k][b];
    tick(2 * CW + 4);
    check(error_pin, 1'b0, "pin after repair");
    wrong = good ^ (32'h00000001 << $urandom_range(31));
    i_crc_partner.scan_expected(wrong, old);
    check(old, good, "shifted out");
    check(user_mode_out, 1'b1, "mode during scan");
    check(tdo_oe, 1'b0, "data output released after scan");
    tick(2 * CW + 4);
    check(signature_out, good ^ wrong, "injected signature");
    check(error_pin, 1'b1, "injected pin");
    i_crc_partner.scan_expected(good, old);
    check(old, wrong, "shifted out again");
    tick(2 * CW + 4);
    check(signature_out, SIGNATURE_OK, "restored signature");
    reset_in = 1'b1;
    tick(1);
    reset_in = 1'b0;
    check(user_mode_out, 1'b0, "mode after reset");
    send_frame(16'h0001 << $urandom_range(15));
    enter_user(good, 1'b0);
    check(status_n_out, 1'b0, "status held");
    final_report();
  end
endmodule
`default_nettype wire
